// file: src/dac_ctrl_pkg.sv
package dac_ctrl_pkg;
    localparam int WORD_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int CNT_BITS = 5;
    localparam logic [4:0] LAST_BIT = 5'h10;
    localparam int BIT_CHAN = 15;
    localparam int BIT_RANGE = 14;
    localparam int BIT_MODE_HI = 13;
    localparam int BIT_MODE_LO = 12;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_HIZ = 2'h3;
    localparam logic [CODE_BITS-1:0] CODE_RESET = 12'h000;
    localparam int CLK_MHZ = 100;
    // settling after power-down exit, 5 V figure, in nanoseconds
    localparam int WAKE_NS = 2500;
    localparam int WAKE_CYCLES = (WAKE_NS * CLK_MHZ) / 1000;
    localparam int WAKE_W = 12;
    typedef enum logic [1:0] {
        IDLE,
        SHIFT,
        DONE
    } frame_state_type;
    // per-channel register contents: range, mode, code
    typedef struct packed {
        logic range;
        logic [1:0] mode;
        logic [CODE_BITS-1:0] code;
    } chan_word_type;
    localparam chan_word_type CHAN_RESET = '{1'b0, MODE_NORMAL, CODE_RESET};
endpackage

// file: src/chan_regs_if.sv
`timescale 1ns/100ps
interface chan_regs_if;
    import dac_ctrl_pkg::*;
    logic write_stb;
    chan_word_type write_word;
    logic load_outputs_n;
    chan_word_type dac_word;
    logic pending;
    modport ctrl (output write_stb, output write_word, output load_outputs_n,
        input dac_word, input pending);
    modport chan (input write_stb, input write_word, input load_outputs_n,
        output dac_word, output pending);
endinterface

// file: src/dac_channel.sv
`timescale 1ns/100ps
module dac_channel
    import dac_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clear_n,
    chan_regs_if.chan bus
);
    chan_word_type input_q;
    chan_word_type dac_q;
    logic pending_q;

    assign bus.dac_word = dac_q;
    assign bus.pending = pending_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            input_q <= CHAN_RESET;
        end else if (!clear_n) begin
            input_q <= CHAN_RESET;
        end else if (bus.write_stb) begin
            input_q <= bus.write_word;
        end
    end

    // a write in the same cycle as a transfer keeps pending set, so it is not lost
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pending_q <= 1'b0;
        end else if (!clear_n) begin
            pending_q <= 1'b0;
        end else if (bus.write_stb) begin
            pending_q <= 1'b1;
        end else if (!bus.load_outputs_n) begin
            pending_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dac_q <= CHAN_RESET;
        end else if (!clear_n) begin
            dac_q <= CHAN_RESET;
        end else if (!bus.load_outputs_n && pending_q) begin
            dac_q <= input_q;
        end
    end
endmodule

// file: src/dac_serial_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// - sixteen-bit word, MSB first, control first
// - bit 15 picks channel A or B
// - bit 14 sets range, resets to zero
// - bits 13:12 select normal or power-down mode
// - low twelve bits are code, variants truncate
// - sample data on falling clock while frame low
// - ignore pulses after sixteenth until new frame
// - full word goes to selected input register
// - early frame end aborts, registers unchanged
// - load strobe low makes converter registers follow
// - load converter register only if input changed
// - clear forces all registers to zero at the next clock edge
// - power-down keeps all register contents
// - power-down pin forces both channels high impedance
// - outputs valid after settling delay on wake
// - input buffers gated off after full word
// - power-on leaves all registers zero, single range
module dac_serial_ctrl
    import dac_ctrl_pkg::*;
#(
    // code bits actually used: 12, 10 or 8
    parameter int RESOLUTION = 12
) (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic FRAME_N,
    input wire logic SCLK,
    input wire logic SDIN,
    input wire logic LOAD_OUTPUTS_N,
    input wire logic ASYNC_CLEAR_N,
    input wire logic POWER_DOWN_PIN_N,
    output logic [CODE_BITS-1:0] CODE_A,
    output logic [CODE_BITS-1:0] CODE_B,
    output logic RANGE_A,
    output logic RANGE_B,
    output logic [1:0] MODE_A,
    output logic [1:0] MODE_B,
    output logic VALID_A,
    output logic VALID_B,
    output logic INPUT_BUF_EN,
    output logic WRITE_DONE
);
    // two-stage synchronisers; stage one is read only by stage two
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic frame_prev_q;
    logic sclk_prev_q;
    logic clear_sync1_q;
    logic clear_sync2_q;

    // pins idle high, so the chain resets high and no false edge follows reset
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            sync1_q <= 5'h1F;
        end else begin
            sync1_q <= {POWER_DOWN_PIN_N, LOAD_OUTPUTS_N, SDIN, SCLK, FRAME_N};
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            sync2_q <= 5'h1F;
        end else begin
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            frame_prev_q <= 1'b1;
        end else begin
            frame_prev_q <= sync2_q[0];
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            sclk_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= sync2_q[1];
        end
    end

    // clear is asynchronous in assert: it acts at once through the reset path
    // of a stretched flag, and its release is synchronised
    always_ff @(posedge MCLK or negedge ASYNC_CLEAR_N) begin
        if (!ASYNC_CLEAR_N) begin
            clear_sync1_q <= 1'b0;
        end else begin
            clear_sync1_q <= 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge ASYNC_CLEAR_N) begin
        if (!ASYNC_CLEAR_N) begin
            clear_sync2_q <= 1'b0;
        end else begin
            clear_sync2_q <= clear_sync1_q;
        end
    end

    logic frame_n;
    logic sclk_s;
    logic sdin_s;
    logic load_n;
    logic pd_pin_n;
    logic frame_fall;
    logic sclk_fall;
    assign frame_n = sync2_q[0];
    assign sclk_s = sync2_q[1];
    assign sdin_s = sync2_q[2];
    assign load_n = sync2_q[3];
    assign pd_pin_n = sync2_q[4];
    assign frame_fall = frame_prev_q && !frame_n;
    assign sclk_fall = sclk_prev_q && !sclk_s;

    frame_state_type state_q;
    logic [CNT_BITS-1:0] count_q;
    logic [WORD_BITS-1:0] shift_q;
    logic done_q;
    logic bit_take;
    logic last_take;
    logic buf_off_q;
    assign bit_take = state_q == SHIFT && !frame_n && sclk_fall;
    assign last_take = bit_take && count_q == LAST_BIT - 5'h01;

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= IDLE;
        end else begin
            unique case (state_q)
                IDLE: begin
                    if (frame_fall) begin
                        state_q <= SHIFT;
                    end
                end
                SHIFT: begin
                    if (frame_n) begin
                        state_q <= IDLE;
                    end else if (last_take) begin
                        state_q <= DONE;
                    end
                end
                DONE: begin
                    if (frame_n) begin
                        state_q <= IDLE;
                    end
                end
                default: begin
                    state_q <= IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            count_q <= '0;
        end else if (frame_fall) begin
            count_q <= '0;
        end else if (bit_take) begin
            count_q <= count_q + 5'h01;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            shift_q <= '0;
        end else if (frame_fall) begin
            shift_q <= '0;
        end else if (bit_take) begin
            shift_q <= {shift_q[WORD_BITS-2:0], sdin_s};
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            done_q <= 1'b0;
        end else begin
            done_q <= last_take;
        end
    end

    // buffers stay off from the full word until the next frame opens, not
    // when the frame closes, so trailing pulses after the word cost nothing
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            buf_off_q <= 1'b0;
        end else if (frame_fall) begin
            buf_off_q <= 1'b0;
        end else if (last_take) begin
            buf_off_q <= 1'b1;
        end
    end

    // word decode; dropped code bits read as zero for narrower variants
    chan_word_type word;
    logic [CODE_BITS-1:0] code_mask;
    assign code_mask = {CODE_BITS{1'b1}} << (CODE_BITS - RESOLUTION);
    always_comb begin
        word.range = shift_q[BIT_RANGE];
        word.mode = {shift_q[BIT_MODE_HI], shift_q[BIT_MODE_LO]};
        word.code = shift_q[CODE_BITS-1:0] & code_mask;
    end

    chan_regs_if if_a ();
    chan_regs_if if_b ();
    assign if_a.write_stb = done_q && !shift_q[BIT_CHAN];
    assign if_b.write_stb = done_q && shift_q[BIT_CHAN];
    assign if_a.write_word = word;
    assign if_b.write_word = word;
    assign if_a.load_outputs_n = load_n;
    assign if_b.load_outputs_n = load_n;

    // power-down never touches the register contents
    dac_channel u_chan_a (
        .clk(MCLK),
        .rst_b(RST_B),
        .clear_n(clear_sync2_q),
        .bus(if_a)
    );
    dac_channel u_chan_b (
        .clk(MCLK),
        .rst_b(RST_B),
        .clear_n(clear_sync2_q),
        .bus(if_b)
    );

    logic [1:0] eff_mode_a;
    logic [1:0] eff_mode_b;
    assign eff_mode_a = pd_pin_n ? if_a.dac_word.mode : MODE_HIZ;
    assign eff_mode_b = pd_pin_n ? if_b.dac_word.mode : MODE_HIZ;

    // wake counters: settling after leaving power-down
    logic [WAKE_W-1:0] wake_a_q;
    logic [WAKE_W-1:0] wake_b_q;
    localparam logic [WAKE_W-1:0] WAKE_LOAD = WAKE_W'(WAKE_CYCLES);

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            wake_a_q <= '0;
        end else if (eff_mode_a != MODE_NORMAL) begin
            wake_a_q <= WAKE_LOAD;
        end else if (wake_a_q != '0) begin
            wake_a_q <= wake_a_q - WAKE_W'(1);
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            wake_b_q <= '0;
        end else if (eff_mode_b != MODE_NORMAL) begin
            wake_b_q <= WAKE_LOAD;
        end else if (wake_b_q != '0) begin
            wake_b_q <= wake_b_q - WAKE_W'(1);
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            CODE_A <= CODE_RESET;
            CODE_B <= CODE_RESET;
        end else begin
            CODE_A <= if_a.dac_word.code;
            CODE_B <= if_b.dac_word.code;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            RANGE_A <= 1'b0;
            RANGE_B <= 1'b0;
        end else begin
            RANGE_A <= if_a.dac_word.range;
            RANGE_B <= if_b.dac_word.range;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            MODE_A <= MODE_NORMAL;
            MODE_B <= MODE_NORMAL;
        end else begin
            MODE_A <= eff_mode_a;
            MODE_B <= eff_mode_b;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            VALID_A <= 1'b1;
            VALID_B <= 1'b1;
        end else begin
            VALID_A <= eff_mode_a == MODE_NORMAL && wake_a_q == '0;
            VALID_B <= eff_mode_b == MODE_NORMAL && wake_b_q == '0;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            INPUT_BUF_EN <= 1'b1;
        end else begin
            INPUT_BUF_EN <= !buf_off_q;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            WRITE_DONE <= 1'b0;
        end else begin
            WRITE_DONE <= done_q;
        end
    end
endmodule

// file: dv/dac_serial_chk.sv
`timescale 1ns/100ps
module dac_serial_chk
    import dac_ctrl_pkg::*;
#(
    parameter int RESOLUTION = 12
) (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic FRAME_N,
    input wire logic LOAD_OUTPUTS_N,
    input wire logic ASYNC_CLEAR_N,
    input wire logic POWER_DOWN_PIN_N,
    input wire logic [CODE_BITS-1:0] CODE_A,
    input wire logic [CODE_BITS-1:0] CODE_B,
    input wire logic [1:0] MODE_A,
    input wire logic [1:0] MODE_B,
    input wire logic VALID_A,
    input wire logic INPUT_BUF_EN,
    input wire logic WRITE_DONE
);
    localparam logic [CODE_BITS-1:0] LOW_MASK = CODE_BITS'((1 << (CODE_BITS - RESOLUTION)) - 1);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    // six idle cycles cover the pin synchronisers and both register stages
    sequence load_idle;
        (LOAD_OUTPUTS_N && ASYNC_CLEAR_N) [*6];
    endsequence
    sequence frame_idle;
        FRAME_N [*6];
    endsequence
    sequence pin_down;
        !POWER_DOWN_PIN_N [*5];
    endsequence
    clear_zero_a: assert property (!ASYNC_CLEAR_N |-> ##2 (CODE_A == '0 && CODE_B == '0))
        else $error("clear left a code nonzero");
    pd_hiz_a: assert property (pin_down |-> MODE_A == MODE_HIZ && MODE_B == MODE_HIZ)
        else $error("power-down pin did not force high impedance");
    one_word_a: assert property (WRITE_DONE |=> !WRITE_DONE [*8])
        else $error("second word accepted too soon");
    buf_off_a: assert property (WRITE_DONE |-> ##[0:2] !INPUT_BUF_EN)
        else $error("input buffers stayed on after full word");
    buf_wake_a: assert property ($rose(INPUT_BUF_EN) |-> !FRAME_N)
        else $error("input buffers woke without a new frame");
    dac_hold_a: assert property (load_idle |-> $stable(CODE_A) && $stable(CODE_B))
        else $error("converter code moved while load high");
    code_mask_a: assert property (((CODE_A | CODE_B) & LOW_MASK) == '0)
        else $error("ignored low code bits not zero");
    idle_no_write_a: assert property (frame_idle |-> !WRITE_DONE)
        else $error("word accepted outside a frame");
    sleep_invalid_a: assert property ((MODE_A != MODE_NORMAL) [*3] |-> !VALID_A)
        else $error("output valid while powered down");
endmodule

bind dac_serial_ctrl dac_serial_chk #(.RESOLUTION(RESOLUTION)) chk_u (
    .MCLK(MCLK), .RST_B(RST_B), .FRAME_N(FRAME_N), .LOAD_OUTPUTS_N(LOAD_OUTPUTS_N),
    .ASYNC_CLEAR_N(ASYNC_CLEAR_N), .POWER_DOWN_PIN_N(POWER_DOWN_PIN_N),
    .CODE_A(CODE_A), .CODE_B(CODE_B), .MODE_A(MODE_A), .MODE_B(MODE_B),
    .VALID_A(VALID_A), .INPUT_BUF_EN(INPUT_BUF_EN), .WRITE_DONE(WRITE_DONE)
);

// file: dv/serial_host.sv
`timescale 1ns/100ps
module serial_host (
    output logic frame_n,
    output logic sclk,
    output logic sdin
);
    initial begin
        frame_n = 1'b1;
        sclk = 1'b1;
        sdin = 1'b1;
    end
    // n below 16 aborts the frame, above 16 repeats the word as surplus pulses
    task automatic send(input logic [15:0] word, input int n);
        frame_n = 1'b0;
        #53;
        for (int i = 0; i < n; i++) begin
            sdin = word[15 - (i % 16)];
            #40 sclk = 1'b0;
            #40 sclk = 1'b1;
        end
        #40 frame_n = 1'b1;
        // released data line shows the inverse so a stale bit cannot pass
        sdin = ~sdin;
        #60;
    endtask
endmodule

// file: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
    import dac_ctrl_pkg::*;
    typedef struct packed {
        logic [15:0] word;
        logic [14:0] exp;
    } row_type;
    logic mclk, rst_b, frame_n, sclk, sdin, load_n, clear_n, pd_n;
    logic [CODE_BITS-1:0] code_a, code_b;
    logic [1:0] mode_a, mode_b;
    logic range_a, range_b, valid_a, valid_b, buf_en, done;
    logic [14:0] exp_a, exp_b;
    int miscompares = 0, num_checks = 0, done_cnt = 0, exp_done = 0;
    // variant with ten code bits: the two lowest read back as zero
    row_type rows [5] = '{'{16'h4ABF, 15'h4ABC}, '{16'hB123, 15'h3120},
        '{16'h1FFF, 15'h1FFC}, '{16'hE804, 15'h6804}, '{16'h0000, 15'h0000}};
    serial_host host_u (.frame_n(frame_n), .sclk(sclk), .sdin(sdin));
    dac_serial_ctrl #(.RESOLUTION(10)) dut_u (
        .MCLK(mclk), .RST_B(rst_b), .FRAME_N(frame_n), .SCLK(sclk), .SDIN(sdin),
        .LOAD_OUTPUTS_N(load_n), .ASYNC_CLEAR_N(clear_n), .POWER_DOWN_PIN_N(pd_n),
        .CODE_A(code_a), .CODE_B(code_b), .RANGE_A(range_a), .RANGE_B(range_b),
        .MODE_A(mode_a), .MODE_B(mode_b), .VALID_A(valid_a), .VALID_B(valid_b),
        .INPUT_BUF_EN(buf_en), .WRITE_DONE(done)
    );
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(negedge mclk) if (done === 1'b1) done_cnt++;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic check_chans();
        check({range_a, mode_a, code_a}, exp_a);
        check({range_b, mode_b, code_b}, exp_b);
        check(16'(done_cnt), 16'(exp_done));
    endtask
    task automatic write(input logic [15:0] word, input int n);
        host_u.send(word, n);
        repeat (10) @(negedge mclk);
    endtask
    task automatic load();
        @(negedge mclk);
        load_n = 1'b0;
        repeat (2) @(negedge mclk);
        load_n = 1'b1;
        repeat (6) @(negedge mclk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        rst_b = 1'b0;
        load_n = 1'b1;
        clear_n = 1'b1;
        pd_n = 1'b1;
        exp_a = '0;
        exp_b = '0;
        repeat (10) @(negedge mclk);
        rst_b = 1'b1;
        repeat (3) @(negedge mclk);
        check_chans();
        check({valid_a, valid_b, buf_en}, 16'h0007);
        $display("test reset end");
        foreach (rows[i]) begin
            write(rows[i].word, 16);
            check(buf_en, 16'h0000);
            exp_done++;
            if (rows[i].word[BIT_CHAN]) begin
                exp_b = rows[i].exp;
            end else begin
                exp_a = rows[i].exp;
            end
            load();
            check_chans();
        end
        $display("test rows end");
        write(16'hC555, 9);
        check(buf_en, 16'h0001);
        load();
        check_chans();
        $display("test abort end");
        write(16'h0AA8, 20);
        exp_done++;
        exp_a = 15'h0AA8;
        load();
        check_chans();
        $display("test surplus end");
        write(16'h0123, 16);
        exp_done++;
        check_chans();
        exp_a = 15'h0120;
        load();
        check_chans();
        $display("test hold end");
        pd_n = 1'b0;
        repeat (8) @(negedge mclk);
        check({mode_a, mode_b, code_a}, {MODE_HIZ, MODE_HIZ, 12'h120});
        pd_n = 1'b1;
        repeat (100) @(negedge mclk);
        check(valid_a, 16'h0000);
        repeat (200) @(negedge mclk);
        check(valid_a, 16'h0001);
        check(valid_b, 16'h0000);
        $display("test power-down end");
        clear_n = 1'b0;
        repeat (3) @(negedge mclk);
        exp_a = '0;
        exp_b = '0;
        check_chans();
        clear_n = 1'b1;
        $display("test clear end");
        end_of_test();
    end
endmodule
